// File: hw/axis_cfg_if.sv
`timescale 1ns/1ps
interface axis_cfg_if;
    logic [7:0] filter_code;
    logic [7:0] polarity;

    modport ctrl (output filter_code, output polarity);
    modport axis (input filter_code, input polarity);
endinterface : axis_cfg_if

// File: hw/axis_cfg_pkg.sv
package axis_cfg_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int NUM_AXES = 16;
    localparam int AXIS_STRIDE = 10;
    localparam int ADDR_W = 17;
    localparam int IDX_W = ADDR_W - 2;
    localparam int OFF_W = 4;
    localparam int AX_W = 4;

    // ------------------------------------------------------------
    // Register indices of axis 1 (byte address = 4 * index)
    // ------------------------------------------------------------
    localparam logic [IDX_W-1:0] REG_FIRMWARE_VERSION_IDX = 15'h4268;
    localparam logic [IDX_W-1:0] REG_SERVO_FILTER_SELECT_IDX = 15'h4269;
    localparam logic [IDX_W-1:0] REG_INPUT_POLARITY_INVERT_IDX = 15'h426a;
    localparam logic [IDX_W-1:0] REG_HOME_DIRECTION_IDX = 15'h426b;
    localparam logic [IDX_W-1:0] REG_CAM_ROW_BYTE_COUNT_IDX = 15'h426d;

    // Offsets inside one axis block
    localparam logic [OFF_W-1:0] OFF_FIRMWARE = OFF_W'(REG_FIRMWARE_VERSION_IDX
                                                 - REG_FIRMWARE_VERSION_IDX);
    localparam logic [OFF_W-1:0] OFF_FILTER = OFF_W'(REG_SERVO_FILTER_SELECT_IDX
                                               - REG_FIRMWARE_VERSION_IDX);
    localparam logic [OFF_W-1:0] OFF_POLARITY = OFF_W'(REG_INPUT_POLARITY_INVERT_IDX
                                                 - REG_FIRMWARE_VERSION_IDX);
    localparam logic [OFF_W-1:0] OFF_HOME_DIR = OFF_W'(REG_HOME_DIRECTION_IDX
                                                 - REG_FIRMWARE_VERSION_IDX);
    localparam logic [OFF_W-1:0] OFF_CAM_ROW = OFF_W'(REG_CAM_ROW_BYTE_COUNT_IDX
                                                - REG_FIRMWARE_VERSION_IDX);

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] FILTER_RESET = 8'h00;
    localparam logic [7:0] POLARITY_RESET = 8'h00;
    localparam logic [31:0] HOME_DIR_RESET = 32'h0000_0000;

    // ------------------------------------------------------------
    // Filter selection codes
    // ------------------------------------------------------------
    localparam logic [7:0] FILT_DEFAULT_PID = 8'h00;
    localparam logic [7:0] FILT_DIRECT_CCW = 8'h01;
    localparam logic [7:0] FILT_DIRECT_CW = 8'h02;
    localparam logic [7:0] FILT_PID = 8'h03;
    localparam logic [7:0] FILT_ALTERNATE = 8'h05;
    localparam logic [7:0] FILT_VIRTUAL_MASTER = 8'h07;
    localparam logic [7:0] FILT_ENCODER_FOLLOW = 8'h80;

    typedef enum logic [2:0] {
        MODE_PID,
        MODE_DIRECT_CCW,
        MODE_DIRECT_CW,
        MODE_ALTERNATE_LOOP_FILTER,
        MODE_VIRTUAL_MASTER,
        MODE_ENCODER_FOLLOW
    } filter_mode_type;

    // ------------------------------------------------------------
    // Polarity bit positions
    // ------------------------------------------------------------
    localparam int POL_HOME_BIT = 1;
    localparam int POL_START_BIT = 2;
    localparam int POL_KILL_BIT = 3;
    localparam int POL_REV_LIMIT_BIT = 4;
    localparam int POL_FWD_LIMIT_BIT = 5;
    localparam int POL_INDEX_BIT = 6;
    localparam logic [7:0] POL_WRITABLE_MASK = 8'h36;

endpackage : axis_cfg_pkg

// File: hw/axis_input_cond.sv
`timescale 1ns/1ps
module axis_input_cond
    import axis_cfg_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    axis_cfg_if.axis cfg,
    input wire logic [7:0] raw_in,
    output logic [7:0] active,
    output logic [2:0] filter_mode,
    output logic encoder_follow
);
    logic [7:0] meta_q;
    logic [7:0] sync_q;
    filter_mode_type mode_d;

    // ------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= 8'h00;
            sync_q <= 8'h00;
        end else begin
            meta_q <= raw_in;
            sync_q <= meta_q;
        end
    end

    // ------------------------------------------------------------
    // Polarity
    // ------------------------------------------------------------
    // Masking again here keeps kill and index open even if storage changes
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            active <= 8'h00;
        end else begin
            active <= sync_q ^ (cfg.polarity & POL_WRITABLE_MASK); // RULE4 RULE5 RULE6
        end
    end

    // ------------------------------------------------------------
    // Filter decode
    // ------------------------------------------------------------
    always_comb begin
        unique case (cfg.filter_code) // RULE1 RULE2
            FILT_DEFAULT_PID: mode_d = MODE_PID;
            FILT_PID: mode_d = MODE_PID;
            FILT_DIRECT_CCW: mode_d = MODE_DIRECT_CCW;
            FILT_DIRECT_CW: mode_d = MODE_DIRECT_CW;
            FILT_ALTERNATE: mode_d = MODE_ALTERNATE_LOOP_FILTER;
            FILT_VIRTUAL_MASTER: mode_d = MODE_VIRTUAL_MASTER;
            FILT_ENCODER_FOLLOW: mode_d = MODE_ENCODER_FOLLOW;
            // Undefined codes fall back to the default loop
            default: mode_d = MODE_PID;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            filter_mode <= MODE_PID;
            encoder_follow <= 1'b0;
        end else begin
            filter_mode <= mode_d;
            encoder_follow <= (mode_d == MODE_ENCODER_FOLLOW); // RULE2
        end
    end

endmodule : axis_input_cond

// File: hw/servo_axis_feature_config.sv
// Functional notes
// (RULE1) Filter code picks loop: 0/3 PID, 1 CCW, 2 CW, 5 alternate, 7 virtual master.
// (RULE2) Filter code 128 puts the axis into encoder-following mode.
// (RULE3) Software sets the filter before the first motion profile command.
// (RULE4) Each set polarity bit inverts its input, making it normally closed.
// (RULE5) Bit 1 home, 2 start, 4 reverse limit, 5 forward limit; 0, 7 unused.
// (RULE6) Kill (bit 3) and index (bit 6) stay normally open always.
// (RULE7) Read-only register gives bytes per cam-table row.
// (RULE8) Writes to firmware version and cam row width are ignored.
`timescale 1ns/1ps
module servo_axis_feature_config
    import axis_cfg_pkg::*;
#(
    parameter logic [31:0] FIRMWARE_VERSION = 32'h0000_0100, // Arbitrary value
    parameter logic [31:0] CAM_ROW_BYTES = 32'h0000_0010
)
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [NUM_AXES-1:0] home_in,
    input wire logic [NUM_AXES-1:0] start_in,
    input wire logic [NUM_AXES-1:0] kill_in,
    input wire logic [NUM_AXES-1:0] rev_limit_in,
    input wire logic [NUM_AXES-1:0] fwd_limit_in,
    input wire logic [NUM_AXES-1:0] index_in,
    output logic [NUM_AXES-1:0] home_active,
    output logic [NUM_AXES-1:0] start_active,
    output logic [NUM_AXES-1:0] kill_active,
    output logic [NUM_AXES-1:0] rev_limit_active,
    output logic [NUM_AXES-1:0] fwd_limit_active,
    output logic [NUM_AXES-1:0] index_active,
    output logic [NUM_AXES*3-1:0] filter_mode,
    output logic [NUM_AXES-1:0] encoder_follow,
    output logic [NUM_AXES-1:0] home_dir_cw
);
    // ------------------------------------------------------------
    // Shared state
    // ------------------------------------------------------------
    logic ack_q;
    logic take;
    logic [IDX_W-1:0] word_idx;
    logic sel_hit;
    logic [AX_W-1:0] sel_axis;
    logic [OFF_W-1:0] sel_off;
    logic [31:0] rdata_d;
    logic [7:0] filter_q [NUM_AXES];
    logic [7:0] polarity_q [NUM_AXES];
    logic [31:0] home_dir_q [NUM_AXES];

    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------
    // One wait cycle per access; read data are registered in it
    // Fixed latency keeps the answer path free of per-register timing;
    // the cost is one idle cycle on every access
    assign take = (avs_read | avs_write) & ~ack_q;
    assign avs_waitrequest = take;
    assign word_idx = avs_address[ADDR_W-1:2];

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= take;
        end
    end

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    always_comb begin
        sel_hit = 1'b0;
        sel_axis = '0;
        sel_off = '0;
        // Each axis owns ten words; holes inside a block still hit but read zero
        // Words outside all sixteen blocks miss and are ignored
        for (int a = 0; a < NUM_AXES; a++) begin
            if (word_idx >= IDX_W'(REG_FIRMWARE_VERSION_IDX + a * AXIS_STRIDE) &&
                word_idx < IDX_W'(REG_FIRMWARE_VERSION_IDX + (a + 1) * AXIS_STRIDE)) begin
                sel_hit = 1'b1;
                sel_axis = AX_W'(a);
                sel_off = OFF_W'(word_idx - IDX_W'(REG_FIRMWARE_VERSION_IDX
                                                   + a * AXIS_STRIDE));
            end
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (sel_hit) begin
            unique case (sel_off)
                OFF_FIRMWARE: rdata_d = FIRMWARE_VERSION;
                OFF_FILTER: rdata_d = {24'h00_0000, filter_q[sel_axis]};
                OFF_POLARITY: rdata_d = {24'h00_0000, polarity_q[sel_axis]};
                OFF_HOME_DIR: rdata_d = home_dir_q[sel_axis];
                OFF_CAM_ROW: rdata_d = CAM_ROW_BYTES; // RULE7
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // Loaded only when a read is taken, so the word stands until the next read
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            avs_readdata <= 32'h0000_0000;
        end else if (take && avs_read) begin
            avs_readdata <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // Per-axis storage and input conditioning
    // ------------------------------------------------------------
    genvar g;
    generate
        // Every axis repeats the same register set and input path
        for (g = 0; g < NUM_AXES; g++) begin : g_axis
            logic wr_axis;
            logic wr_filter;
            logic wr_polarity;
            logic wr_home_dir;
            logic home_dir_pos;
            logic [7:0] active;
            axis_cfg_if cfg_bus ();

            // ----------------------------------------------------
            // Write strobes
            // ----------------------------------------------------
            // Firmware and cam row offsets have no storage, so writes there drop
            assign wr_axis = take && avs_write && sel_hit && (sel_axis == AX_W'(g)); // RULE8
            // Filter and polarity are one byte wide and only follow lane 0
            assign wr_filter = wr_axis && (sel_off == OFF_FILTER) && avs_byteenable[0];
            assign wr_polarity = wr_axis && (sel_off == OFF_POLARITY) && avs_byteenable[0];
            assign wr_home_dir = wr_axis && (sel_off == OFF_HOME_DIR);

            // ----------------------------------------------------
            // Filter selection
            // ----------------------------------------------------
            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    filter_q[g] <= FILTER_RESET;
                end else if (wr_filter) begin
                    // Taken at any time; filter_mode follows one clock later whether or not motion has started
                    filter_q[g] <= avs_writedata[7:0]; // RULE1 RULE2
                end
            end

            // ----------------------------------------------------
            // Input polarity
            // ----------------------------------------------------
            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    polarity_q[g] <= POLARITY_RESET;
                end else if (wr_polarity) begin
                    polarity_q[g] <= avs_writedata[7:0] & POL_WRITABLE_MASK; // RULE5 RULE6
                end
            end

            // ----------------------------------------------------
            // Home direction
            // ----------------------------------------------------
            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    home_dir_q[g] <= HOME_DIR_RESET;
                end else if (wr_home_dir) begin
                    for (int b = 0; b < 4; b++) begin
                        if (avs_byteenable[b]) begin
                            home_dir_q[g][b*8 +: 8] <= avs_writedata[b*8 +: 8];
                        end
                    end
                end
            end

            // Positive value means clockwise; zero and negative mean counter-clockwise
            assign home_dir_pos = !home_dir_q[g][31] && (home_dir_q[g] != 32'h0000_0000);

            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    home_dir_cw[g] <= 1'b0;
                end else begin
                    home_dir_cw[g] <= home_dir_pos;
                end
            end

            // ----------------------------------------------------
            // Input conditioning
            // ----------------------------------------------------
            assign cfg_bus.filter_code = filter_q[g];
            assign cfg_bus.polarity = polarity_q[g];

            axis_input_cond u_cond (
                .core_clk(core_clk),
                .rstn(rstn),
                .cfg(cfg_bus.axis),
                .raw_in({1'b0, index_in[g], fwd_limit_in[g], rev_limit_in[g],
                         kill_in[g], start_in[g], home_in[g], 1'b0}),
                .active(active),
                .filter_mode(filter_mode[g*3 +: 3]),
                .encoder_follow(encoder_follow[g])
            );

            // ----------------------------------------------------
            // Conditioned inputs per axis
            // ----------------------------------------------------
            assign home_active[g] = active[POL_HOME_BIT]; // RULE4
            assign start_active[g] = active[POL_START_BIT];
            assign kill_active[g] = active[POL_KILL_BIT];
            assign rev_limit_active[g] = active[POL_REV_LIMIT_BIT];
            assign fwd_limit_active[g] = active[POL_FWD_LIMIT_BIT];
            assign index_active[g] = active[POL_INDEX_BIT];
        end
    endgenerate

endmodule : servo_axis_feature_config

// File: tb/servo_axis_feature_config_properties.sv
`timescale 1ns/1ps
module servo_axis_feature_config_checker
    import axis_cfg_pkg::*;
#(
    parameter logic [31:0] FIRMWARE_VERSION = 32'h0000_0100,
    parameter logic [31:0] CAM_ROW_BYTES = 32'h0000_0010
)
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [NUM_AXES-1:0] kill_in,
    input wire logic [NUM_AXES-1:0] index_in,
    input wire logic [NUM_AXES-1:0] kill_active,
    input wire logic [NUM_AXES-1:0] index_active,
    input wire logic [NUM_AXES*3-1:0] filter_mode,
    input wire logic [NUM_AXES-1:0] encoder_follow
);
    // Register and filter checks watch axis 1 only; kill and index checks cover all sixteen axes
    localparam logic [ADDR_W-1:0] A_FW = {REG_FIRMWARE_VERSION_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] A_FILT = {REG_SERVO_FILTER_SELECT_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] A_POL = {REG_INPUT_POLARITY_INVERT_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] A_CAM = {REG_CAM_ROW_BYTE_COUNT_IDX, 2'h0};

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    sequence s_rd(logic [ADDR_W-1:0] a);
        avs_read && avs_waitrequest && avs_address == a;
    endsequence
    sequence s_wr_filt(logic [7:0] code);
        avs_write && avs_waitrequest && avs_address == A_FILT && avs_byteenable[0]
            && avs_writedata[7:0] == code;
    endsequence
    sequence s_first_cycle;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence

    property p_wait_first;
        $rose(avs_read || avs_write) |-> avs_waitrequest;
    endproperty
    property p_wait_one;
        s_first_cycle ##1 (avs_read || avs_write) |-> !avs_waitrequest;
    endproperty
    property p_follow;
        s_wr_filt(8'h80) |-> ##2 encoder_follow[0];
    endproperty
    property p_alternate;
        s_wr_filt(8'h05) |-> ##2 (filter_mode[2:0] == 3'h3 && !encoder_follow[0]);
    endproperty
    property p_virtual;
        s_wr_filt(8'h07) |-> ##2 filter_mode[2:0] == 3'h4;
    endproperty
    property p_fw_read;
        s_rd(A_FW) |=> avs_readdata == FIRMWARE_VERSION;
    endproperty
    property p_cam_read;
        s_rd(A_CAM) |=> avs_readdata == CAM_ROW_BYTES;
    endproperty
    property p_pol_read;
        s_rd(A_POL) |=> (avs_readdata & ~32'h0000_0036) == 32'h0;
    endproperty
    property p_kill_open;
        $stable(kill_in)[*6] |-> kill_active == kill_in;
    endproperty
    property p_index_open;
        $stable(index_in)[*6] |-> index_active == index_in;
    endproperty

    a_wait_first:
        assert property (p_wait_first) else $error("No wait state on first access cycle");
    a_wait_one:
        assert property (p_wait_one) else $error("Access not answered after one wait");
    a_follow:
        assert property (p_follow) else $error("Code 128 did not select following");
    a_alternate:
        assert property (p_alternate) else $error("Code 5 did not select alternate");
    a_virtual:
        assert property (p_virtual) else $error("Code 7 did not select virtual master");
    a_fw_read:
        assert property (p_fw_read) else $error("Firmware version read wrong");
    a_cam_read:
        assert property (p_cam_read) else $error("Cam row width read wrong");
    a_pol_read:
        assert property (p_pol_read) else $error("Fixed polarity bit read as set");
    a_kill_open:
        assert property (p_kill_open) else $error("Kill input inverted");
    a_index_open:
        assert property (p_index_open) else $error("Index input inverted");
endmodule : servo_axis_feature_config_checker

bind servo_axis_feature_config servo_axis_feature_config_checker #(
    .FIRMWARE_VERSION(FIRMWARE_VERSION), .CAM_ROW_BYTES(CAM_ROW_BYTES)
) u_chk (.core_clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .kill_in, .index_in,
    .kill_active, .index_active, .filter_mode, .encoder_follow);

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench
    import axis_cfg_pkg::*;
;
    localparam logic [31:0] FW = 32'h0000_0100; // Arbitrary value
    localparam logic [31:0] CAM = 32'h0000_0010;
    logic core_clk = 1'h0, rstn = 1'h0, avs_read = 1'h0, avs_write = 1'h0, avs_waitrequest;
    logic [ADDR_W-1:0] avs_address = '0;
    logic [31:0] avs_writedata = '0, avs_readdata, rd;
    logic [3:0] avs_byteenable = 4'hf;
    logic [NUM_AXES-1:0] home_in = '0, start_in = '0, kill_in = '0, rev_limit_in = '0;
    logic [NUM_AXES-1:0] fwd_limit_in = '1, index_in = '0;
    logic [NUM_AXES-1:0] home_active, start_active, kill_active, rev_limit_active;
    logic [NUM_AXES-1:0] fwd_limit_active, index_active, encoder_follow, home_dir_cw;
    logic [NUM_AXES*3-1:0] filter_mode;
    logic [7:0] codes [7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h07, 8'h80};
    logic [2:0] modes [7] = '{3'h0, 3'h1, 3'h2, 3'h0, 3'h3, 3'h4, 3'h5};
    int err_total = 0;
    int n_checks = 0;

    always #5 core_clk = ~core_clk;

    servo_axis_feature_config #(.FIRMWARE_VERSION(FW), .CAM_ROW_BYTES(CAM)) DUT (
        .core_clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .home_in, .start_in, .kill_in,
        .rev_limit_in, .fwd_limit_in, .index_in, .home_active, .start_active, .kill_active,
        .rev_limit_active, .fwd_limit_active, .index_active, .filter_mode,
        .encoder_follow, .home_dir_cw);

    function automatic logic [ADDR_W-1:0] ra(input int ax, input logic [IDX_W-1:0] idx);
        return {idx + IDX_W'(AXIS_STRIDE * ax), 2'h0};
    endfunction : ra

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            err_total++;
        end
    endtask : chk

    // ------------------------------------------------------------
    // Bus access
    // ------------------------------------------------------------
    // Waitrequest is sampled at each rising edge; the request stands until
    // it is seen low, and the read word is taken at that same edge
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'h0);
        chk("wait cycles", 32'h2, 32'(n));
        rd = avs_readdata;
        avs_write <= 1'h0;
        avs_read <= 1'h0;
    endtask : xfer

    task automatic settle();
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
    endtask : settle

    task automatic give_verdict();
        $display("Checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        repeat (5000) @(posedge core_clk);
        err_total++;
        give_verdict();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge core_clk);
        rstn <= 1'h1;
        xfer(1'h0, ra(0, REG_SERVO_FILTER_SELECT_IDX), 32'h0);
        chk("filter reset", 32'h0, rd);
        for (int k = 0; k < 2; k++) begin
            xfer(1'h0, ra(0, REG_FIRMWARE_VERSION_IDX), 32'h0);
            chk("firmware", FW, rd);
            xfer(1'h0, ra(0, REG_CAM_ROW_BYTE_COUNT_IDX), 32'h0);
            chk("cam row", CAM, rd);
            xfer(1'h1, ra(0, REG_FIRMWARE_VERSION_IDX), 32'hffff_ffff);
            xfer(1'h1, ra(0, REG_CAM_ROW_BYTE_COUNT_IDX), 32'h0000_0000);
        end
        xfer(1'h0, ra(0, REG_FIRMWARE_VERSION_IDX + 15'h4), 32'h0);
        chk("unmapped", 32'h0, rd);
        foreach (codes[i]) begin
            xfer(1'h1, ra(0, REG_SERVO_FILTER_SELECT_IDX), {24'h0, codes[i]});
            settle();
            chk("filter mode", 32'(modes[i]), 32'(filter_mode[2:0]));
            chk("encoder follow", 32'(codes[i][7]), 32'(encoder_follow[0]));
            xfer(1'h0, ra(0, REG_SERVO_FILTER_SELECT_IDX), 32'h0);
            chk("filter readback", {24'h0, codes[i]}, rd);
        end
        xfer(1'h1, ra(15, REG_SERVO_FILTER_SELECT_IDX), 32'h7);
        settle();
        chk("axis 16 mode", 32'h4, 32'(filter_mode[47:45]));
        chk("axis 1 mode", 32'h5, 32'(filter_mode[2:0]));
        xfer(1'h1, ra(0, REG_INPUT_POLARITY_INVERT_IDX), 32'h0000_00ff);
        xfer(1'h0, ra(0, REG_INPUT_POLARITY_INVERT_IDX), 32'h0);
        chk("polarity readback", 32'h36, rd);
        settle();
        chk("axis 1 inputs", 32'h0b, {26'h0, index_active[0], fwd_limit_active[0],
            rev_limit_active[0], kill_active[0], start_active[0], home_active[0]});
        chk("axis 2 home", 32'h0, 32'(home_active[1]));
        xfer(1'h1, ra(0, REG_HOME_DIRECTION_IDX), 32'h0000_0001);
        settle();
        chk("home clockwise", 32'h1, 32'(home_dir_cw[0]));
        xfer(1'h1, ra(0, REG_HOME_DIRECTION_IDX), 32'hffff_ffff);
        avs_byteenable <= 4'h1;
        xfer(1'h1, ra(0, REG_HOME_DIRECTION_IDX), 32'h0000_0005);
        avs_byteenable <= 4'hf;
        xfer(1'h0, ra(0, REG_HOME_DIRECTION_IDX), 32'h0);
        chk("home dir lanes", 32'hffff_ff05, rd);
        settle();
        chk("home counter-clockwise", 32'h0, 32'(home_dir_cw[0]));
        @(posedge core_clk);
        kill_in <= 16'h0001;
        index_in <= 16'h0001;
        settle();
        chk("kill and index", 32'h3, {30'h0, index_active[0], kill_active[0]});
        give_verdict();
    end
endmodule : testbench
